/* File: adcsq_chk.sv */
// Checker for the converter sequencer: timing and pairing of its outputs.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module adcsq_chk (
  input wire        clk,
  input wire        rst,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire [1:0]  convActive,
  input wire [1:0]  resolutionMode,
  input wire [7:0]  sampleAmp,
  input wire [3:0]  convAmp,
  input wire [1:0]  intFlagSet,
  input wire [1:0]  dmaReq,
  input wire [23:0] dmaAddr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Busy stretches; a short conversion would break the peak-rate sizing
  sequence s_busy8_0; convActive[0] [*8]; endsequence
  sequence s_busy8_1; convActive[1] [*8]; endsequence

  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_answer; ce && psel && !penable && !pready |=> pready; endproperty
  property p_req_flag; (dmaReq & ~intFlagSet) == 2'b00; endproperty
  property p_flag_pulse; intFlagSet[0] |=> !intFlagSet[0]; endproperty
  property p_flag_end; intFlagSet[0] |-> $fell(convActive[0]); endproperty
  property p_conv10;
    $rose(convActive[0]) && !resolutionMode[0] |-> s_busy8_0 ##1 convActive[0];
  endproperty
  property p_conv12;
    $rose(convActive[1]) && resolutionMode[1] |-> s_busy8_1 ##1 s_busy8_1 ##1 convActive[1] [*3];
  endproperty
  property p_res_frozen; $changed(resolutionMode[0]) |-> !convActive[0]; endproperty
  property p_one_amp;
    resolutionMode[1] |-> sampleAmp[7:5] == 3'b000 && convAmp[3:2] == 2'b00;
  endproperty
  property p_addr_held; $changed(dmaAddr[11:0]) |-> dmaReq[0]; endproperty

  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready stayed high past one cycle");
  a_ready_answer: assert property (p_ready_answer)
    else $error("pready missing after setup");
  a_req_flag: assert property (p_req_flag)
    else $error("dma request without flag");
  a_flag_pulse: assert property (p_flag_pulse)
    else $error("flag pulse too long");
  a_flag_end: assert property (p_flag_end)
    else $error("flag not at end of conversion");
  a_conv10: assert property (p_conv10)
    else $error("10-bit conversion too short");
  a_conv12: assert property (p_conv12)
    else $error("12-bit conversion too short");
  a_res_frozen: assert property (p_res_frozen)
    else $error("resolution changed while converting");
  a_one_amp: assert property (p_one_amp)
    else $error("extra amp used in 12-bit mode");
  a_addr_held: assert property (p_addr_held)
    else $error("dma address moved without request");
endmodule

bind adcsq_top adcsq_chk u_adcsq_chk (
  .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
  .convActive(convActive), .resolutionMode(resolutionMode), .sampleAmp(sampleAmp),
  .convAmp(convAmp), .intFlagSet(intFlagSet), .dmaReq(dmaReq), .dmaAddr(dmaAddr)
);

/* File: adcsq_defines.vh */
// Constants for the converter sequencer: clock and rate figures, register
// indices, field positions, write masks and sequencer codes.
// Assumes a single 10 MHz clock and 32-bit APB access.
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH

// Clock rate and peak conversion rates
`define ADCSQ_CLK_KHZ      10000
`define ADCSQ_RATE10_KSPS  1100
`define ADCSQ_RATE12_KSPS  500

// Address decode: bit 5 picks the converter, bits 4:2 the register
`define ADCSQ_A_TOP        7:6
`define ADCSQ_A_CONV       5
`define ADCSQ_A_IDX        4:2
`define ADCSQ_A_LOW        1:0

// Register indices inside one converter's set
`define ADCSQ_R_CTL1       3'h0
`define ADCSQ_R_CTL2       3'h1
`define ADCSQ_R_CTL3       3'h2
`define ADCSQ_R_CHSEL      3'h3
`define ADCSQ_R_PCFG       3'h4
`define ADCSQ_R_RESULT     3'h5
`define ADCSQ_R_DMACFG     3'h6
`define ADCSQ_R_STATUS     3'h7

// Control one fields
`define ADCSQ_B_ON         15
`define ADCSQ_B_SIDL       13
`define ADCSQ_B_BUILD      12
`define ADCSQ_B_RES        10
`define ADCSQ_B_FORM       9:8
`define ADCSQ_B_SSRC       7:5
`define ADCSQ_B_SIMSAM     3
`define ADCSQ_B_ASAM       2
`define ADCSQ_B_SAMPLE_ENABLE       1
`define ADCSQ_B_DONE       0
// Control two and three fields
`define ADCSQ_B_VCFG       15:13
`define ADCSQ_B_CSCNA      10
`define ADCSQ_B_CHPS       9:8
`define ADCSQ_B_SMPI       5:2
`define ADCSQ_B_SAMC       12:8
// DMA configuration fields
`define ADCSQ_B_DSEL       0
`define ADCSQ_B_DSIZE      3:1

// Write masks and reset value
`define ADCSQ_CTL1_WMASK   16'hB7EC
`define ADCSQ_CTL2_WMASK   16'hE73C
`define ADCSQ_CTL3_WMASK   16'h1F00
`define ADCSQ_RES_MASK     16'h0400
`define ADCSQ_CTL_RST      16'h0000

// Trigger source and result format codes
`define ADCSQ_SSRC_SW      3'h0
`define ADCSQ_SSRC_EXT     3'h1
`define ADCSQ_SSRC_TMRA    3'h2
`define ADCSQ_SSRC_TMRB    3'h4
`define ADCSQ_SSRC_AUTO    3'h7
`define ADCSQ_FORM_SIGNED  2'h1

// Sequencer states
`define ADCSQ_ST_OFF       2'h0
`define ADCSQ_ST_HOLD      2'h1
`define ADCSQ_ST_SAMPLE    2'h2
`define ADCSQ_ST_CONV      2'h3

`endif

/* File: adcsq_dma_model.sv */
// DMA controller stand-in: counts requests and latches what each one carries.
// Assumes requests are one-cycle pulses on the shared clock.
`timescale 1ns/1ps
module adcsq_dma_model (
  input  wire        clk,
  input  wire        rst,
  input  wire [1:0]  dmaReq,
  input  wire [23:0] dmaAddr,
  input  wire [31:0] dmaData,
  output logic [7:0]  reqCnt0,
  output logic [7:0]  reqCnt1,
  output logic [23:0] capAddr,
  output logic [31:0] capData
);
  // One transfer per request pulse, address and word taken together
  always @(posedge clk) begin
    if (rst) begin
      reqCnt0 <= 8'h00;
      reqCnt1 <= 8'h00;
      capAddr <= 24'h000000;
      capData <= 32'h00000000;
    end else begin
      if (dmaReq[0]) begin
        reqCnt0 <= reqCnt0 + 8'h01;
        capAddr[11:0] <= dmaAddr[11:0];
        capData[15:0] <= dmaData[15:0];
      end
      if (dmaReq[1]) begin
        reqCnt1 <= reqCnt1 + 8'h01;
        capAddr[23:12] <= dmaAddr[23:12];
        capData[31:16] <= dmaData[31:16];
      end
    end
  end
endmodule

/* File: adcsq_tb.sv */
// Testbench for the converter sequencer: APB setup, conversions, DMA feed.
// Assumes the front-end code on sarData is held steady for the whole run.
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, rerr;
  logic        cpuIdle, timerMatchA, timerMatchB, extIntPin;
  logic [7:0]  paddr, sampleAmp, reqCnt0, reqCnt1;
  logic [31:0] pwdata, prdata, rdat, dmaData, capData;
  logic [23:0] sarData, dmaAddr, capAddr;
  logic [1:0]  convActive, resolutionMode, intFlagSet, dmaReq;
  logic [9:0]  ch0Select;
  logic [3:0]  convAmp;
  logic [5:0]  vrefSel;
  int          mismatches, tests_run, nconv;

  // Idle values; the pins not exercised here stay quiet
  initial begin
    {clk, psel, penable, pwrite, cpuIdle, timerMatchA, timerMatchB, extIntPin} = 8'h00;
    rst = 1'b1;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    sarData = 24'h123ABC;
  end
  always #50 clk = ~clk;

  adcsq_top u_adcsq_top (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuIdle(cpuIdle), .timerMatchA(timerMatchA),
    .timerMatchB(timerMatchB), .extIntPin(extIntPin), .sarData(sarData),
    .convActive(convActive), .resolutionMode(resolutionMode), .sampleAmp(sampleAmp),
    .ch0Select(ch0Select), .convAmp(convAmp), .vrefSel(vrefSel), .intFlagSet(intFlagSet),
    .dmaReq(dmaReq), .dmaAddr(dmaAddr), .dmaData(dmaData));
  adcsq_dma_model u_adcsq_dma_model (.clk(clk), .rst(rst), .dmaReq(dmaReq),
    .dmaAddr(dmaAddr), .dmaData(dmaData), .reqCnt0(reqCnt0), .reqCnt1(reqCnt1),
    .capAddr(capAddr), .capData(capData));

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; holds everything until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) mismatches++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts conversions until the flag pulse; bounded so a stall cannot hang
  task waitFlag(input int c);
    int n;
    logic prev;
    nconv = 0;
    prev = 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (convActive[c] === 1'b1 && !prev) nconv++;
      prev = convActive[c];
    end while (intFlagSet[c] !== 1'b1 && n < 2000);
    if (n == 2000) mismatches++;
    @(posedge clk);
  endtask

  task t_reset;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctl1 reset", rdat, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    chk("unmapped data", rdat, 32'h0);
  endtask

  task t_unsigned10;
    chk("flag idle", {30'h0, intFlagSet}, 32'h0);
    apb(1'b1, 8'h08, 32'h0100);
    apb(1'b1, 8'h18, 32'h0001);
    // The converter must already be on when the sample request lands
    apb(1'b1, 8'h00, 32'h90E0);
    apb(1'b1, 8'h00, 32'h90E2);
    waitFlag(0);
    chk("conv count", nconv, 32'h1);
    chk("dma data0", {16'h0, capData[15:0]}, 32'h02BC);
    chk("dma addr0", {20'h0, capAddr[11:0]}, 32'h0);
    chk("req count0", {24'h0, reqCnt0}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk("result0", rdat, 32'h02BC);
    apb(1'b0, 8'h00, 32'h0);
    chk("done set", rdat, 32'h90E1);
    apb(1'b1, 8'h00, 32'h90E0);
    apb(1'b0, 8'h00, 32'h0);
    chk("done clear", rdat, 32'h90E0);
  endtask

  task t_rate4;
    apb(1'b1, 8'h04, 32'hA00C);
    apb(1'b1, 8'h00, 32'h90E6);
    waitFlag(0);
    chk("ops per flag", nconv, 32'h4);
    chk("order addr", {20'h0, capAddr[11:0]}, 32'h3);
    chk("req count0 b", {24'h0, reqCnt0}, 32'h2);
    chk("vref sel", {29'h0, vrefSel[2:0]}, 32'h5);
    apb(1'b1, 8'h00, 32'h0);
  endtask

  task t_signed12;
    apb(1'b1, 8'h28, 32'h0100);
    apb(1'b1, 8'h2C, 32'h0005);
    apb(1'b1, 8'h38, 32'h0005);
    apb(1'b1, 8'h20, 32'h0500);
    @(posedge clk);
    chk("res mode", {30'h0, resolutionMode}, 32'h2);
    apb(1'b1, 8'h20, 32'h85E0);
    apb(1'b1, 8'h20, 32'h85E2);
    waitFlag(1);
    chk("amp0 input", {27'h0, ch0Select[9:5]}, 32'h5);
    chk("conv count1", nconv, 32'h1);
    chk("dma data1", {16'h0, capData[31:16]}, 32'hF923);
    chk("gather addr", {20'h0, capAddr[23:12]}, 32'h014);
    chk("req count1", {24'h0, reqCnt1}, 32'h1);
    apb(1'b1, 8'h20, 32'h81E0);
    @(posedge clk);
    chk("res kept", {31'h0, resolutionMode[1]}, 32'h1);
    apb(1'b1, 8'h20, 32'h0);
  endtask

  // Four amps sampled together, software trigger, one flag per sequence
  task t_simul4;
    apb(1'b1, 8'h04, 32'h030C);
    apb(1'b1, 8'h00, 32'h9008);
    apb(1'b1, 8'h00, 32'h900A);
    @(posedge clk);
    chk("amps tracking", {28'h0, sampleAmp[3:0]}, 32'hF);
    apb(1'b1, 8'h00, 32'h9008);
    waitFlag(0);
    chk("seq count", nconv, 32'h1);
    chk("last amp", {30'h0, convAmp[1:0]}, 32'h3);
    chk("amps held", {28'h0, sampleAmp[3:0]}, 32'h0);
    chk("req count0 c", {24'h0, reqCnt0}, 32'h3);
    apb(1'b1, 8'h00, 32'h0);
  endtask

  task conclude;
    $display("Summary: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence after 20 cycles of reset
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_unsigned10;
    t_rate4;
    t_simul4;
    t_signed12;
    conclude;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(100 * 20000);
    mismatches++;
    conclude;
  end
endmodule

/* File: adcsq_top.v */
// Two converter sequencers with APB registers, result formatting and DMA feed.
// Assumes the analog front end holds sarData stable while convActive is high.
// Function
// - Two converters, each with its own register set.
// - Resolution bit picks 10-bit four-amp or 12-bit one-amp operation.
// - 10-bit mode samples up to four inputs at once.
// - 12-bit mode has one amp, no simultaneous sampling.
// - Channel select spans inputs 0 to 31.
// - Conversion timing gives 1 Msps (10-bit, short of 1.1 Msps) and 500 ksps (12-bit) peak rates.
// - Scanning, trigger choice, buffer fill and two result formats.
// - Converter keeps running in processor sleep, and in idle unless SIDL is set.
// - Each flag setting issues one DMA request when selected.
// - Increment-rate field sets how often the DMA pointer advances.
// - Build-order one: DMA address is the operation count at the flag, which equals the rate code.
// - Build-order zero: scatter/gather address from input index and size.
// - Rate code plus one gives operations per advance or flag.
// - Format 00 unsigned, 01 signed with inverted top bits.
// - Trigger 000 software, 111 auto counter, 001 edge, 010 and 100 timer, other codes never trigger.
// - Done sets on completion, clears on start; software clear only.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "adcsq_defines.vh"

module adcsq_top (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        cpuIdle,
  input  wire        timerMatchA,
  input  wire        timerMatchB,
  input  wire        extIntPin,
  input  wire [23:0] sarData,
  output wire [1:0]  convActive,
  output wire [1:0]  resolutionMode,
  output wire [7:0]  sampleAmp,
  output wire [9:0]  ch0Select,
  output wire [3:0]  convAmp,
  output wire [5:0]  vrefSel,
  output wire [1:0]  intFlagSet,
  output wire [1:0]  dmaReq,
  output wire [23:0] dmaAddr,
  output wire [31:0] dmaData
);

  // Conversion phase length; at least one sample cycle completes the period
  localparam integer CONV10_N =
    (`ADCSQ_CLK_KHZ + `ADCSQ_RATE10_KSPS - 1) / `ADCSQ_RATE10_KSPS - 1;
  localparam integer CONV12_N =
    (`ADCSQ_CLK_KHZ + `ADCSQ_RATE12_KSPS - 1) / `ADCSQ_RATE12_KSPS - 1;
  // Counts fit five bits; cut on purpose from the integer figures
  localparam [4:0]   CONV10   = CONV10_N[4:0];
  localparam [4:0]   CONV12   = CONV12_N[4:0];

  wire        access = psel & penable & pready;
  wire        wrEn   = access & pwrite;
  wire        mapped = (paddr[`ADCSQ_A_TOP] == 2'b00) && (paddr[`ADCSQ_A_LOW] == 2'b00);
  wire [31:0] cvRd [0:1];
  reg         ext1;
  reg         ext2;
  reg         ext3;
  wire        extEdge = ext2 & ~ext3;

  // Format a raw code into a right-justified word
  function [15:0] fmtRes(input res12, input [1:0] form, input [11:0] d);
    begin
      if (form == `ADCSQ_FORM_SIGNED)
        fmtRes = res12 ? {{5{~d[11]}}, d[10:0]} : {{7{~d[9]}}, d[8:0]};
      else
        fmtRes = res12 ? {4'h0, d} : {6'h00, d[9:0]};
    end
  endfunction

  // Next analog pin in the scan mask after the current one
  function [4:0] nextScan(input [4:0] cur, input [31:0] mask);
    integer   i;
    reg [4:0] c;
    reg       found;
    begin
      nextScan = cur;
      found = 1'b0;
      for (i = 1; i <= 32; i = i + 1) begin
        c = cur + i[4:0];
        if (!found && mask[c]) begin
          nextScan = c;
          found = 1'b1;
        end
      end
    end
  endfunction

  // External trigger pin synchroniser and edge history
  always @(posedge clk) begin
    if (rst) begin
      ext1 <= 1'b0;
      ext2 <= 1'b0;
      ext3 <= 1'b0;
    end else if (ce) begin
      ext1 <= extIntPin;
      ext2 <= ext1;
      ext3 <= ext2;
    end
  end

  // APB slave: one wait-free access cycle, read data latched at setup
  always @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & ~penable & ~pready;
      if (psel && !penable) begin
        prdata  <= mapped ? cvRd[paddr[`ADCSQ_A_CONV]] : 32'h00000000;
        pslverr <= ~mapped;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : cv
      reg  [15:0] ctl1;
      reg  [15:0] ctl2;
      reg  [15:0] ctl3;
      reg  [4:0]  chsel;
      reg  [31:0] pcfg;
      reg  [3:0]  dmacfg;
      reg  [15:0] result;
      reg  [1:0]  state;
      reg  [1:0]  ampIdx;
      reg  [4:0]  cnt;
      reg  [3:0]  opCnt;
      reg  [6:0]  slot;
      reg  [11:0] sar1;
      reg  [11:0] sar2;
      reg  [3:0]  track;
      reg  [4:0]  curChan;
      reg         sample_enable;
      reg         done;
      reg         busy;
      reg         flag;
      reg         dreq;
      reg  [11:0] daddr;
      reg  [15:0] ddata;
      reg  [31:0] rdv;
      reg         endSample;

      wire       wrK    = wrEn & mapped & (paddr[`ADCSQ_A_CONV] == g);
      wire       wrC1   = wrK & (paddr[`ADCSQ_A_IDX] == `ADCSQ_R_CTL1);
      wire       on     = ctl1[`ADCSQ_B_ON];
      wire       res12  = ctl1[`ADCSQ_B_RES];
      wire       simsam = ctl1[`ADCSQ_B_SIMSAM] & ~res12;
      wire [1:0] chps   = res12 ? 2'b00 : ctl2[`ADCSQ_B_CHPS];
      wire [3:0] ampMask = (chps == 2'b00) ? 4'h1 : (chps == 2'b01) ? 4'h3 : 4'hF;
      wire [1:0] lastAmp = (chps == 2'b00) ? 2'h0 : (chps == 2'b01) ? 2'h1 : 2'h3;
      wire [4:0] convLast = res12 ? CONV12 - 5'h01 : CONV10 - 5'h01;
      wire [4:0] samcEff = (ctl3[`ADCSQ_B_SAMC] == 5'h00) ? 5'h01 : ctl3[`ADCSQ_B_SAMC];
      wire       tmrA = (g == 0) ? timerMatchA : timerMatchB;
      wire       tmrB = (g == 0) ? timerMatchB : timerMatchA;
      // Idle stop is optional; sleep never stops the sequencer
      wire       run = on & ~(cpuIdle & ctl1[`ADCSQ_B_SIDL]);
      wire [15:0] fmtW = fmtRes(res12, ctl1[`ADCSQ_B_FORM], sar2);
      wire [4:0]  chanNow = (ampIdx == 2'h0) ? curChan : {3'b000, ampIdx};
      wire [2:0]  dsize = dmacfg[`ADCSQ_B_DSIZE];
      wire [6:0]  sizeMask = (7'h01 << dsize) - 7'h01;
      wire [11:0] sgAddr = ({7'h00, chanNow} << dsize) | {5'h00, slot};

      // Trigger that ends sampling and starts conversion
      always @* begin
        case (ctl1[`ADCSQ_B_SSRC])
          `ADCSQ_SSRC_SW:   endSample = wrC1 & ~pwdata[`ADCSQ_B_SAMPLE_ENABLE];
          `ADCSQ_SSRC_EXT:  endSample = extEdge;
          `ADCSQ_SSRC_TMRA: endSample = tmrA;
          `ADCSQ_SSRC_TMRB: endSample = tmrB;
          `ADCSQ_SSRC_AUTO: endSample = (cnt + 5'h01) >= samcEff;
          default:          endSample = 1'b0;
        endcase
      end

      // Register writes and the sample/convert sequencer share one process
      always @(posedge clk) begin
        if (rst) begin
          ctl1 <= `ADCSQ_CTL_RST;
          ctl2 <= `ADCSQ_CTL_RST;
          ctl3 <= `ADCSQ_CTL_RST;
          chsel <= 5'h00;
          pcfg <= 32'h00000000;
          dmacfg <= 4'h0;
          result <= 16'h0000;
          state <= `ADCSQ_ST_OFF;
          ampIdx <= 2'h0;
          cnt <= 5'h00;
          opCnt <= 4'h0;
          slot <= 7'h00;
          sar1 <= 12'h000;
          sar2 <= 12'h000;
          track <= 4'h0;
          curChan <= 5'h00;
          sample_enable <= 1'b0;
          done <= 1'b0;
          busy <= 1'b0;
          flag <= 1'b0;
          dreq <= 1'b0;
          daddr <= 12'h000;
          ddata <= 16'h0000;
        end else if (ce) begin
          flag <= 1'b0;
          dreq <= 1'b0;
          sar1 <= sarData[g*12 +: 12];
          sar2 <= sar1;
          if (wrK) begin
            case (paddr[`ADCSQ_A_IDX])
              `ADCSQ_R_CTL1: begin
                // Resolution is frozen while the converter runs
                ctl1 <= (pwdata[15:0] & `ADCSQ_CTL1_WMASK & ~`ADCSQ_RES_MASK) |
                        ((on ? ctl1 : pwdata[15:0]) & `ADCSQ_RES_MASK);
                if (!pwdata[`ADCSQ_B_DONE])
                  done <= 1'b0;
              end
              `ADCSQ_R_CTL2:   ctl2 <= pwdata[15:0] & `ADCSQ_CTL2_WMASK;
              `ADCSQ_R_CTL3:   ctl3 <= pwdata[15:0] & `ADCSQ_CTL3_WMASK;
              `ADCSQ_R_CHSEL:  chsel <= pwdata[4:0];
              `ADCSQ_R_PCFG:   pcfg <= pwdata;
              `ADCSQ_R_DMACFG: dmacfg <= pwdata[3:0];
              default: ;
            endcase
          end
          if (!ctl2[`ADCSQ_B_CSCNA] && state != `ADCSQ_ST_CONV)
            curChan <= chsel;
          if (!on) begin
            state <= `ADCSQ_ST_OFF;
            sample_enable <= 1'b0;
            busy <= 1'b0;
            track <= 4'h0;
            ampIdx <= 2'h0;
            cnt <= 5'h00;
          end else if (run) begin
            case (state)
              `ADCSQ_ST_OFF, `ADCSQ_ST_HOLD: begin
                if (ctl1[`ADCSQ_B_ASAM] || (wrC1 && pwdata[`ADCSQ_B_SAMPLE_ENABLE])) begin
                  state <= `ADCSQ_ST_SAMPLE;
                  sample_enable <= 1'b1;
                  track <= ampMask;
                  cnt <= 5'h00;
                end else begin
                  state <= `ADCSQ_ST_HOLD;
                end
              end
              `ADCSQ_ST_SAMPLE: begin
                cnt <= cnt + 5'h01;
                if (endSample) begin
                  state <= `ADCSQ_ST_CONV;
                  sample_enable <= 1'b0;
                  done <= 1'b0;
                  busy <= 1'b1;
                  ampIdx <= 2'h0;
                  cnt <= 5'h00;
                  track <= simsam ? 4'h0 : (ampMask & 4'hE);
                end
              end
              `ADCSQ_ST_CONV: begin
                cnt <= cnt + 5'h01;
                if (cnt == convLast) begin
                  cnt <= 5'h00;
                  result <= fmtW;
                  // Flag and DMA once per programmed number of operations
                  if (opCnt == ctl2[`ADCSQ_B_SMPI]) begin
                    opCnt <= 4'h0;
                    flag <= 1'b1;
                    dreq <= dmacfg[`ADCSQ_B_DSEL];
                    ddata <= fmtW;
                    daddr <= ctl1[`ADCSQ_B_BUILD] ? {8'h00, opCnt} : sgAddr;
                    slot <= (slot + 7'h01) & sizeMask;
                  end else begin
                    opCnt <= opCnt + 4'h1;
                  end
                  if (ampIdx == lastAmp) begin
                    done <= 1'b1;
                    busy <= 1'b0;
                    if (ctl2[`ADCSQ_B_CSCNA])
                      curChan <= nextScan(curChan, pcfg);
                    if (ctl1[`ADCSQ_B_ASAM]) begin
                      state <= `ADCSQ_ST_SAMPLE;
                      sample_enable <= 1'b1;
                      track <= ampMask;
                    end else begin
                      state <= `ADCSQ_ST_HOLD;
                      track <= 4'h0;
                    end
                  end else begin
                    ampIdx <= ampIdx + 2'h1;
                    if (!simsam)
                      track <= track & ~(4'h1 << (ampIdx + 2'h1));
                  end
                end
              end
              default: state <= `ADCSQ_ST_OFF;
            endcase
          end
        end
      end

      // Read view; unimplemented bits read as zero
      always @* begin
        rdv = 32'h00000000;
        case (paddr[`ADCSQ_A_IDX])
          `ADCSQ_R_CTL1: begin
            rdv[15:0] = ctl1;
            rdv[`ADCSQ_B_SIMSAM] = simsam;
            rdv[`ADCSQ_B_SAMPLE_ENABLE] = sample_enable;
            rdv[`ADCSQ_B_DONE] = done;
          end
          `ADCSQ_R_CTL2: begin
            rdv[15:0] = ctl2;
            rdv[`ADCSQ_B_CHPS] = chps;
          end
          `ADCSQ_R_CTL3:   rdv[15:0] = ctl3;
          `ADCSQ_R_CHSEL:  rdv[4:0] = chsel;
          `ADCSQ_R_PCFG:   rdv = pcfg;
          `ADCSQ_R_RESULT: rdv[15:0] = result;
          `ADCSQ_R_DMACFG: rdv[3:0] = dmacfg;
          `ADCSQ_R_STATUS: rdv[14:0] = {opCnt, ampIdx, busy, state, curChan, done};
          default:         rdv = 32'h00000000;
        endcase
      end

      assign cvRd[g]              = rdv;
      assign convActive[g]        = busy;
      assign resolutionMode[g]    = res12;
      assign sampleAmp[g*4 +: 4]  = track;
      assign ch0Select[g*5 +: 5]  = curChan;
      assign convAmp[g*2 +: 2]    = ampIdx;
      assign vrefSel[g*3 +: 3]    = ctl2[`ADCSQ_B_VCFG];
      assign intFlagSet[g]        = flag;
      assign dmaReq[g]            = dreq;
      assign dmaAddr[g*12 +: 12]  = daddr;
      assign dmaData[g*16 +: 16]  = ddata;
    end
  endgenerate

endmodule
